/* File: rtl/pad_ctl_defines.svh */
// register offsets, field positions and reset values of the pad control block
`ifndef PAD_CTL_DEFINES_SVH
`define PAD_CTL_DEFINES_SVH
`define OFS_TX_CTRL 8'h00
`define OFS_PORT_PULLUP 8'h04
`define OFS_PORT_E_SEL 8'h08
`define OFS_PORT_E_DIR 8'h0C
`define OFS_PORT_E_OUT 8'h10
`define OFS_PORT_E_PUR 8'h14
`define OFS_PORT_E_IN 8'h18
`define OFS_SYS_PUDR 8'h1C
`define OFS_IRQ_CFG 8'h20
`define OFS_INT_STAT 8'h24
`define OFS_INT_MASK 8'h28
`define OFS_PWR_MODE 8'h2C
`define TX_PUSHPULL_BIT 0
`define TX_SWDRIVE_BIT 1
`define TX_SWLEVEL_BIT 2
`define SYS_PUDR_IRQ_BIT 0
`define TX_CTRL_RST 3'h0
`define PORT_PULLUP_RST 1'h1
`define PORT_E_SEL_RST 6'h00
`define PORT_E_DIR_RST 6'h00
`define PORT_E_OUT_RST 6'h00
`define PORT_E_PUR_RST 6'h3F
`define SYS_PUDR_RST 1'h0
`define IRQ_CFG_RST 2'h0
`define INT_MASK_RST 2'h0
`endif

/* File: rtl/pad_ctl_pkg.sv */
// types shared by the pad control block
package pad_ctl_pkg;
    typedef logic [5:0] port_e_vec_t;
    typedef logic [1:0] irq_vec_t;
    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_WAIT = 2'h1,
        PWR_STOP = 2'h2
    } pwr_mode_t;
endpackage

/* File: rtl/pad_pullup_and_ext_irq.sv */
// pad pull-up control, timer/port E pin muxing and external interrupt conditioning
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "pad_ctl_defines.svh"
module pad_pullup_and_ext_irq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // transmit pin
    input wire logic tx_data_i,
    output logic tx_pin_o,
    output logic tx_pin_oe_o,
    output logic tx_pullup_o,
    // timer c/d pins shared with port e lines 8..13
    input wire logic [5:0] timer_out_i,
    input wire logic [5:0] timer_oe_i,
    output logic [5:0] timer_in_o,
    input wire pad_ctl_pkg::port_e_vec_t port_e_pin_i,
    output pad_ctl_pkg::port_e_vec_t port_e_pin_o,
    output pad_ctl_pkg::port_e_vec_t port_e_pin_oe_o,
    output pad_ctl_pkg::port_e_vec_t port_e_pullup_o,
    // external interrupt requests, active low
    input wire pad_ctl_pkg::irq_vec_t ext_int_request_n_i,
    output pad_ctl_pkg::irq_vec_t ext_int_pullup_o,
    output pad_ctl_pkg::irq_vec_t ext_int_o,
    output logic wake_o,
    output logic irq_o
);
    import pad_ctl_pkg::*;

    logic [2:0] tx_ctrl;
    logic port_pullup_enable_reg;
    port_e_vec_t port_e_sel;
    port_e_vec_t port_e_dir;
    port_e_vec_t port_e_out;
    port_e_vec_t port_e_pullup_reg;
    logic system_pullup_disable_reg;
    irq_vec_t irq_cfg;
    irq_vec_t int_stat;
    irq_vec_t int_mask;
    pwr_mode_t pwr_mode;
    port_e_vec_t pe_meta;
    port_e_vec_t pe_sync;
    irq_vec_t irq_meta;
    irq_vec_t irq_sync;
    irq_vec_t irq_prev;
    irq_vec_t irq_event;
    logic wr_en;
    logic rd_en;
    logic tx_level;
    logic low_power;
    logic [31:0] next_rdata;

    function automatic logic [31:0] zext6(input logic [5:0] v);
        zext6 = {26'h0000000, v};
    endfunction

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign low_power = (pwr_mode == PWR_STOP) || (pwr_mode == PWR_WAIT);
    assign tx_level = tx_ctrl[`TX_SWDRIVE_BIT] ? tx_ctrl[`TX_SWLEVEL_BIT] : tx_data_i;

    // bus acknowledge, one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ctrl <= `TX_CTRL_RST;
            port_pullup_enable_reg <= `PORT_PULLUP_RST;
            port_e_sel <= `PORT_E_SEL_RST;
            port_e_dir <= `PORT_E_DIR_RST;
            port_e_out <= `PORT_E_OUT_RST;
            port_e_pullup_reg <= `PORT_E_PUR_RST;
            system_pullup_disable_reg <= `SYS_PUDR_RST;
            irq_cfg <= `IRQ_CFG_RST;
            int_mask <= `INT_MASK_RST;
            pwr_mode <= PWR_RUN;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                `OFS_TX_CTRL: tx_ctrl <= wb_dat_i[2:0];
                `OFS_PORT_PULLUP: port_pullup_enable_reg <= wb_dat_i[0];
                `OFS_PORT_E_SEL: port_e_sel <= wb_dat_i[5:0];
                `OFS_PORT_E_DIR: port_e_dir <= wb_dat_i[5:0];
                `OFS_PORT_E_OUT: port_e_out <= wb_dat_i[5:0];
                `OFS_PORT_E_PUR: port_e_pullup_reg <= wb_dat_i[5:0];
                `OFS_SYS_PUDR: system_pullup_disable_reg <= wb_dat_i[`SYS_PUDR_IRQ_BIT];
                `OFS_IRQ_CFG: irq_cfg <= wb_dat_i[1:0];
                `OFS_INT_MASK: int_mask <= wb_dat_i[1:0];
                `OFS_PWR_MODE: begin
                    if (wb_dat_i[1:0] == 2'h1) begin
                        pwr_mode <= PWR_WAIT;
                    end else if (wb_dat_i[1:0] == 2'h2) begin
                        pwr_mode <= PWR_STOP;
                    end else begin
                        pwr_mode <= PWR_RUN;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data mux
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (wb_adr_i)
            `OFS_TX_CTRL: next_rdata = {29'h00000000, tx_ctrl};
            `OFS_PORT_PULLUP: next_rdata = {31'h00000000, port_pullup_enable_reg};
            `OFS_PORT_E_SEL: next_rdata = zext6(port_e_sel);
            `OFS_PORT_E_DIR: next_rdata = zext6(port_e_dir);
            `OFS_PORT_E_OUT: next_rdata = zext6(port_e_out);
            `OFS_PORT_E_PUR: next_rdata = zext6(port_e_pullup_reg);
            `OFS_PORT_E_IN: next_rdata = zext6(pe_sync);
            `OFS_SYS_PUDR: next_rdata = {31'h00000000, system_pullup_disable_reg};
            `OFS_IRQ_CFG: next_rdata = {30'h00000000, irq_cfg};
            `OFS_INT_STAT: next_rdata = {30'h00000000, int_stat};
            `OFS_INT_MASK: next_rdata = {30'h00000000, int_mask};
            `OFS_PWR_MODE: next_rdata = {30'h00000000, pwr_mode};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd_en) begin
            wb_dat_o <= next_rdata;
        end
    end

    // transmit pin drive and pull-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_pin_o <= 1'b0;
            tx_pin_oe_o <= 1'b0;
            tx_pullup_o <= 1'b1;
        end else if (tx_ctrl[`TX_PUSHPULL_BIT]) begin
            tx_pin_o <= tx_level;
            tx_pin_oe_o <= 1'b1;
            tx_pullup_o <= 1'b0;
        end else begin
            tx_pin_o <= 1'b0;
            tx_pin_oe_o <= !tx_level;
            tx_pullup_o <= tx_level && port_pullup_enable_reg;
        end
    end

    // port e input synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pe_meta <= 6'h00;
            pe_sync <= 6'h00;
        end else begin
            pe_meta <= port_e_pin_i;
            pe_sync <= pe_meta;
        end
    end

    // timer c/d versus port e pin muxing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_e_pin_o <= 6'h00;
            port_e_pin_oe_o <= 6'h00;
            port_e_pullup_o <= `PORT_E_PUR_RST;
            timer_in_o <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (port_e_sel[i]) begin
                    port_e_pin_o[i] <= port_e_out[i];
                    port_e_pin_oe_o[i] <= port_e_dir[i];
                end else begin
                    port_e_pin_o[i] <= timer_out_i[i];
                    port_e_pin_oe_o[i] <= timer_oe_i[i];
                end
            end
            port_e_pullup_o <= port_e_pullup_reg;
            timer_in_o <= pe_sync;
        end
    end

    // external request synchroniser and detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_meta <= 2'h3;
            irq_sync <= 2'h3;
            irq_prev <= 2'h3;
        end else begin
            irq_meta <= ext_int_request_n_i;
            irq_sync <= irq_meta;
            irq_prev <= irq_sync;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            irq_event[i] = irq_cfg[i] ? (irq_prev[i] && !irq_sync[i]) : !irq_sync[i];
        end
    end

    // sticky status, cleared by a read, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_stat <= 2'h0;
        end else if (rd_en && wb_adr_i == `OFS_INT_STAT) begin
            int_stat <= irq_event;
        end else begin
            int_stat <= int_stat | irq_event;
        end
    end

    // interrupt outputs, wake path and request pull-ups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_int_o <= 2'h0;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
            ext_int_pullup_o <= 2'h3;
        end else begin
            ext_int_o <= irq_event;
            irq_o <= |((int_stat | irq_event) & int_mask);
            // low level recognised straight from the pad in low power
            wake_o <= low_power && !(&ext_int_request_n_i);
            ext_int_pullup_o <= {2{!system_pullup_disable_reg}};
        end
    end

    // checks
    AST_OD_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_ctrl[`TX_PUSHPULL_BIT] && !tx_level |=> !tx_pullup_o && tx_pin_oe_o)
        else $error("pull-up on while open-drain drives low");
    AST_OD_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_ctrl[`TX_PUSHPULL_BIT] |=> !tx_pin_o)
        else $error("open-drain pin driven high");
    AST_OD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_ctrl[`TX_PUSHPULL_BIT] && tx_level |=> tx_pullup_o == $past(port_pullup_enable_reg))
        else $error("open-drain high pull-up wrong");
    AST_PP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_ctrl[`TX_PUSHPULL_BIT] |=> !tx_pullup_o && tx_pin_o == $past(tx_level))
        else $error("push-pull pull-up on");
    AST_RST_TX: assert property (@(posedge clk_i)
        $fell(rst_i) |-> tx_pullup_o && !tx_ctrl[`TX_PUSHPULL_BIT])
        else $error("transmit pin reset state wrong");
    AST_RST_TIMER: assert property (@(posedge clk_i)
        $fell(rst_i) |-> port_e_sel == 6'h00)
        else $error("timer pins not in timer mode after reset");
    AST_TIMER_PATH: assert property (@(posedge clk_i) disable iff (rst_i)
        port_e_sel == 6'h00
        |=> port_e_pin_o == $past(timer_out_i) && port_e_pin_oe_o == $past(timer_oe_i))
        else $error("timer drive not on pins");
    AST_GPIO_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        port_e_sel[0] ##1 port_e_sel[0] |-> port_e_pin_oe_o[0] == $past(port_e_dir[0]))
        else $error("port line direction wrong");
    AST_PE_PUR: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 port_e_pullup_o == $past(port_e_pullup_reg))
        else $error("port e pull-up mismatch");
    AST_RST_PUR: assert property (@(posedge clk_i)
        $fell(rst_i) |-> port_e_pullup_o == `PORT_E_PUR_RST && ext_int_pullup_o == 2'h3)
        else $error("pull-ups not on after reset");
    AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power && ext_int_request_n_i == 2'h2 |=> wake_o)
        else $error("low power request missed");
    AST_RUN_NO_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        !low_power |=> !wake_o)
        else $error("wake raised outside low power");
    AST_SYNC_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !irq_cfg[0] && $fell(ext_int_request_n_i[0]) ##1 !ext_int_request_n_i[0]
        |=> irq_event[0])
        else $error("level request not seen two cycles later");
    AST_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_cfg[1] && !irq_sync[1] && !irq_prev[1] |-> !irq_event[1])
        else $error("edge mode fired on steady low");
    AST_EDGE_FIRE: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_cfg[0] && irq_prev[0] && !irq_sync[0] |=> ext_int_o[0])
        else $error("falling edge not reported");
    AST_STAT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_event != 2'h0 |=> (int_stat & $past(irq_event)) == $past(irq_event))
        else $error("event did not set status");
    AST_LVL_STAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !irq_cfg[0] && !irq_sync[0] |=> int_stat[0])
        else $error("low level not held in status");
    AST_PUDR: assert property (@(posedge clk_i) disable iff (rst_i)
        system_pullup_disable_reg ##1 system_pullup_disable_reg |-> ext_int_pullup_o == 2'h0)
        else $error("request pull-ups not disabled");
    AST_PUDR_ON: assert property (@(posedge clk_i) disable iff (rst_i)
        !system_pullup_disable_reg ##1 !system_pullup_disable_reg |-> ext_int_pullup_o == 2'h3)
        else $error("request pull-ups not enabled");
    AST_STAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_en && wb_adr_i == `OFS_INT_STAT && irq_event == 2'h0 |=> int_stat == 2'h0)
        else $error("status not cleared by read");
    AST_STAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !(rd_en && wb_adr_i == `OFS_INT_STAT) && irq_event == 2'h0 |=> $stable(int_stat))
        else $error("status changed without cause");
    AST_IRQ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        (int_stat & int_mask) != 2'h0 |=> irq_o)
        else $error("unmasked status without interrupt");
    AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        ((int_stat | irq_event) & int_mask) == 2'h0 |=> !irq_o)
        else $error("interrupt without unmasked status");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    AST_ACK_TAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    AST_WR_LAND: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == `OFS_INT_MASK |=> int_mask == $past(wb_dat_i[1:0]))
        else $error("write did not land");
    CV_EDGE: cover property (@(posedge clk_i) irq_cfg[0] && irq_event[0]);
    CV_WAKE: cover property (@(posedge clk_i) wake_o);
    CV_IRQ: cover property (@(posedge clk_i) irq_o);
    CV_OD: cover property (@(posedge clk_i) tx_pin_oe_o && !tx_pullup_o);
    CV_GPIO: cover property (@(posedge clk_i) port_e_sel[5] && port_e_pin_oe_o[5]);
endmodule

/* File: tb/ext_irq_source.sv */
// external requester and port e pad model
`timescale 1ns/10ps
module ext_irq_source (
    // clock
    input wire logic clk_i,
    // requests and request pull-ups
    input wire logic [1:0] assert_i,
    input wire logic [1:0] req_pullup_i,
    output logic [1:0] req_n_o,
    // port e pads
    input wire logic [5:0] pad_out_i,
    input wire logic [5:0] pad_oe_i,
    input wire logic [5:0] pad_pullup_i,
    output logic [5:0] pad_level_o
);
    logic float_pat = 1'b0;
    // an undriven line with no pull-up wanders
    always_ff @(posedge clk_i) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            req_n_o[i] = assert_i[i] ? 1'b0 : (req_pullup_i[i] ? 1'b1 : float_pat);
        end
        for (int i = 0; i < 6; i++) begin
            pad_level_o[i] = pad_oe_i[i] ? pad_out_i[i] : (pad_pullup_i[i] ? 1'b1 : float_pat);
        end
    end
endmodule

/* File: tb/pad_pullup_and_ext_irq_tb.sv */
// self-checking bench of the pad control block
`timescale 1ns/10ps
`include "pad_ctl_defines.svh"
module pad_pullup_and_ext_irq_tb;
    import pad_ctl_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_data_i, tx_pin_o, tx_pin_oe_o;
    logic tx_pullup_o, wake_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [5:0] timer_out_i, timer_oe_i, timer_in_o;
    logic [1:0] req_on;
    port_e_vec_t port_e_pin_i, port_e_pin_o, port_e_pin_oe_o, port_e_pullup_o;
    irq_vec_t ext_int_request_n_i, ext_int_pullup_o, ext_int_o;
    int n_fail = 0;
    int n_tests = 0;
    pad_pullup_and_ext_irq pad_pullup_and_ext_irq_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_data_i(tx_data_i), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
        .tx_pullup_o(tx_pullup_o), .timer_out_i(timer_out_i), .timer_oe_i(timer_oe_i),
        .timer_in_o(timer_in_o), .port_e_pin_i(port_e_pin_i), .port_e_pin_o(port_e_pin_o),
        .port_e_pin_oe_o(port_e_pin_oe_o), .port_e_pullup_o(port_e_pullup_o),
        .ext_int_request_n_i(ext_int_request_n_i), .ext_int_pullup_o(ext_int_pullup_o),
        .ext_int_o(ext_int_o), .wake_o(wake_o), .irq_o(irq_o));
    ext_irq_source ext_irq_source_inst (.clk_i(clk_i), .assert_i(req_on),
        .req_pullup_i(ext_int_pullup_o), .req_n_o(ext_int_request_n_i),
        .pad_out_i(port_e_pin_o), .pad_oe_i(port_e_pin_oe_o), .pad_pullup_i(port_e_pullup_o),
        .pad_level_o(port_e_pin_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] dat);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            end_of_test();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_cycle(adr, 1'b1, dat);
    endtask
    task rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(adr, 1'b0, 32'h0);
        check(rd, exp);
    endtask
    task settle();
        repeat (3) @(posedge clk_i);
    endtask
    // waits for irq_o (sel 0) or wake_o (sel 1) to reach a level
    task wait_lvl(input logic sel, input logic v);
        int k;
        k = 0;
        while ((sel ? wake_o : irq_o) !== v && k < 20) begin
            @(posedge clk_i);
            k++;
        end
        check(sel ? wake_o : irq_o, v);
        if ((sel ? wake_o : irq_o) !== v) begin
            end_of_test();
        end
    endtask
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        tx_data_i = 1'b1;
        timer_out_i = 6'h2A;
        timer_oe_i = 6'h3F;
        req_on = 2'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check({tx_pullup_o, tx_pin_oe_o}, 2'h2);
        check({port_e_pin_o, port_e_pin_oe_o}, 12'hABF);
        check({ext_int_pullup_o, irq_o}, 3'h6);
        rd_chk(`OFS_TX_CTRL, `TX_CTRL_RST);
        rd_chk(`OFS_PORT_PULLUP, `PORT_PULLUP_RST);
        rd_chk(`OFS_PORT_E_SEL, `PORT_E_SEL_RST);
        rd_chk(`OFS_PORT_E_PUR, `PORT_E_PUR_RST);
        rd_chk(8'h30, 32'h0);
        $display("reset test done");
        tx_data_i <= 1'b0;
        settle();
        check({tx_pin_oe_o, tx_pin_o, tx_pullup_o}, 3'h4);
        tx_data_i <= 1'b1;
        settle();
        check({tx_pin_oe_o, tx_pullup_o}, 2'h1);
        wr(`OFS_PORT_PULLUP, 32'h0);
        settle();
        check(tx_pullup_o, 1'b0);
        wr(`OFS_PORT_PULLUP, 32'h1);
        wr(`OFS_TX_CTRL, 32'h1);
        for (int v = 0; v < 2; v++) begin
            tx_data_i <= v[0];
            settle();
            check({tx_pin_oe_o, tx_pin_o, tx_pullup_o}, {1'b1, v[0], 1'b0});
        end
        wr(`OFS_TX_CTRL, 32'h2);
        settle();
        check({tx_pin_oe_o, tx_pullup_o}, 2'h2);
        wr(`OFS_TX_CTRL, 32'h6);
        tx_data_i <= 1'b0;
        settle();
        check({tx_pin_oe_o, tx_pullup_o}, 2'h1);
        tx_data_i <= 1'b1;
        wr(`OFS_TX_CTRL, 32'h0);
        $display("transmit pin test done");
        wr(`OFS_PORT_E_SEL, 32'h3F);
        wr(`OFS_PORT_E_DIR, 32'h0F);
        wr(`OFS_PORT_E_OUT, 32'h05);
        settle();
        check({port_e_pin_oe_o, port_e_pin_o & 6'h0F}, 12'h3C5);
        rd_chk(`OFS_PORT_E_IN, 32'h35);
        check(timer_in_o, 6'h35);
        wr(`OFS_PORT_E_SEL, 32'h0);
        wr(`OFS_PORT_E_PUR, 32'h15);
        timer_oe_i <= 6'h00;
        settle();
        check(port_e_pullup_o, 6'h15);
        wr(`OFS_PORT_E_PUR, 32'h3F);
        $display("port e test done");
        wr(`OFS_SYS_PUDR, 32'h1);
        settle();
        check(ext_int_pullup_o, 2'h0);
        wr(`OFS_SYS_PUDR, 32'h0);
        settle();
        check(ext_int_pullup_o, 2'h3);
        wb_cycle(`OFS_INT_STAT, 1'b0, 32'h0);
        wr(`OFS_INT_MASK, 32'h3);
        req_on <= 2'h1;
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b0);
        wait_lvl(1'b0, 1'b1);
        check(ext_int_o, 2'h1);
        check(wake_o, 1'b0);
        rd_chk(`OFS_INT_STAT, 32'h1);
        req_on <= 2'h0;
        settle();
        wb_cycle(`OFS_INT_STAT, 1'b0, 32'h0);
        wait_lvl(1'b0, 1'b0);
        wr(`OFS_IRQ_CFG, 32'h3);
        req_on <= 2'h2;
        wait_lvl(1'b0, 1'b1);
        check(ext_int_o, 2'h2);
        rd_chk(`OFS_INT_STAT, 32'h2);
        wait_lvl(1'b0, 1'b0);
        req_on <= 2'h0;
        wr(`OFS_INT_MASK, 32'h1);
        req_on <= 2'h2;
        settle();
        req_on <= 2'h0;
        settle();
        check(irq_o, 1'b0);
        rd_chk(`OFS_INT_STAT, 32'h2);
        $display("request test done");
        for (int m = 1; m < 3; m++) begin
            wr(`OFS_PWR_MODE, m);
            req_on <= 2'h1;
            repeat (2) @(posedge clk_i);
            check(wake_o, 1'b1);
            req_on <= 2'h0;
            wait_lvl(1'b1, 1'b0);
        end
        wr(`OFS_PWR_MODE, 32'h0);
        $display("low power test done");
        end_of_test();
    end
endmodule
